/* File: rtl/tsx_pkg.sv */
/*
  Package for the tape start-stop serial transmitter: register map,
  field positions, reset values, pulse timing and the state record.
  Assumes a 25 MHz pclk and an APB master with 32-bit data.
*/
// What this block does
// (RULE1) Opened run chain stops sending; the line returns to idle marking.
// (RULE2) Each character carries five or six data pulses, selectable.
// (RULE3) Marking lets line current flow; spacing breaks it, one interval each.
// (RULE4) Pulse rate set by software register, never faster than 100 wpm.
// (RULE5) Start only with idle line, drive, tape, circuits complete, run on.
// (RULE6) Each cycle begins by advancing the tape one character.
// (RULE7) All code positions sampled together; perforated means selected.
// (RULE8) Sampled code locked in a holding register before the start pulse.
// (RULE9) The start pulse is always spacing.
// (RULE10) Line output changes only when the new pulse differs.
// (RULE11) Data pulses go out from first position to last after start.
// (RULE12) Run control closes the chain when tape interlocks are closed.
// (RULE13) Every character ends with a marking stop pulse.
// (RULE14) With the chain closed, the next character follows at once.
// (RULE15) No tape reads as all perforated; tape-out opens the run chain.
// (RULE16) Perforation sends marking, no hole spacing; idle line is marking.
// (RULE17) Chain opening mid-character finishes the character before halting.
package tsx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SIX_BIT = 1;
  localparam int EV_CHAR_BIT = 0;
  localparam int EV_HALT_BIT = 1;

  // ----------------------------------------------------------------
  // Timing and widths
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // Shortest pulse interval: 100 wpm, about 13.48 ms per pulse
  localparam int PULSE_MIN_US = 13480;
  localparam int PULSE_MIN_CYC =
    (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 24;
  localparam int CODE_W = 6;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(PULSE_MIN_CYC);
  localparam logic [1:0] MASK_RST = 2'h0;

  // Line levels
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FEED = 3'b001,
    ST_SENSE = 3'b010,
    ST_START = 3'b011,
    ST_DATA = 3'b100,
    ST_STOP = 3'b101
  } tsx_state_t;

  // Tape sensor group
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic tape_present;
    logic tight_tape;
    logic run_sw;
    logic drive_running;
    logic ext_ok;
  } tsx_sense_t;

  // APB answer group
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tsx_apb_rsp_t;

  // Whole state of the transmitter
  typedef struct packed {
    tsx_state_t fsm;
    logic [DIV_W-1:0] cnt;
    logic [2:0] pos;
    logic [CODE_W-1:0] hold;
    logic line;
    logic adv;
    logic chain;
    logic [1:0] ctrl;
    logic [DIV_W-1:0] div;
    logic [1:0] ev;
    logic [1:0] mask;
    logic irq;
    tsx_apb_rsp_t rsp;
  } tsx_regs_t;

endpackage

/* File: rtl/tsx_top.sv */
/*
  Tape start-stop serial transmitter: tape feed and sensing control,
  holding register, pulse timer and neutral line driver, APB registers
  and one level interrupt.
  Assumes sensor inputs are synchronous to pclk; with no tape in the reader
  (tape_present low) the held code is forced to all positions perforated.
*/
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps

module tsx_top #(
  parameter int MIN_PULSE_CYC = tsx_pkg::PULSE_MIN_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Tape reader and interlocks
  input wire tsx_pkg::tsx_sense_t sense,
  output logic tape_advance,
  // Line and interrupt
  output logic line_mark,
  output logic irq
);

  tsx_pkg::tsx_regs_t r_q;
  tsx_pkg::tsx_regs_t r_d;
  logic chain;
  logic go;
  logic tick;
  logic last;
  logic wr;
  logic rd;
  logic [tsx_pkg::DIV_W-1:0] eff_div;
  logic [1:0] ev_set;
  logic [31:0] rdata;
  logic hit;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Keep the current level unless the new pulse differs
  function automatic logic tsx_next_line(input logic cur, input logic want);
    logic res;
    res = cur;
    if (want != cur)
    begin
      res = want; // RULE10
    end
    return res;
  endfunction

  // One cycle off the pulse timer; width kept explicit
  function automatic logic [tsx_pkg::DIV_W-1:0] tsx_dec(
    input logic [tsx_pkg::DIV_W-1:0] cnt
  );
    logic [tsx_pkg::DIV_W-1:0] res;
    res = cnt - tsx_pkg::DIV_W'(1);
    return res;
  endfunction

  // A divisor below the 100 wpm limit would outrun the receivers
  function automatic logic [tsx_pkg::DIV_W-1:0] tsx_clamp(
    input logic [tsx_pkg::DIV_W-1:0] div
  );
    logic [tsx_pkg::DIV_W-1:0] lim;
    lim = tsx_pkg::DIV_W'(MIN_PULSE_CYC);
    return (div < lim) ? lim : div;
  endfunction

  // Final code position for the selected code width
  function automatic logic [2:0] tsx_last_pos(input logic six);
    logic [2:0] res;
    res = six ? 3'h5 : 3'h4;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Run chain and start condition
  // ----------------------------------------------------------------
  // Series chain: run control, tape-out and tight-tape interlocks
  assign chain = sense.run_sw & sense.tape_present & ~sense.tight_tape; // RULE12 RULE15
  assign go = chain & r_q.ctrl[tsx_pkg::CTRL_RUN_BIT] & sense.drive_running
    & sense.ext_ok & (r_q.line == tsx_pkg::LINE_MARK); // RULE5
  // Divisor below the 100 wpm limit is clamped, not trusted
  assign eff_div = tsx_clamp(r_q.div); // RULE4
  assign tick = (r_q.cnt == '0);
  assign last =
    (r_q.pos == tsx_last_pos(r_q.ctrl[tsx_pkg::CTRL_SIX_BIT])); // RULE2

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Access completes on the edge after pready rises: one wait state
  assign wr = psel & penable & pwrite & r_q.rsp.pready;
  assign rd = psel & penable & ~r_q.rsp.pready;

  // Read mux; unmapped addresses answer with an error and zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      tsx_pkg::ADDR_CTRL: rdata[1:0] = r_q.ctrl;
      tsx_pkg::ADDR_DIV: rdata[tsx_pkg::DIV_W-1:0] = r_q.div;
      tsx_pkg::ADDR_STAT:
      begin
        rdata[0] = (r_q.fsm != tsx_pkg::ST_IDLE);
        rdata[1] = r_q.line;
        rdata[2] = r_q.chain;
        rdata[10:8] = r_q.pos;
        rdata[21:16] = r_q.hold;
      end
      tsx_pkg::ADDR_IRQ_STAT: rdata[1:0] = r_q.ev;
      tsx_pkg::ADDR_IRQ_MASK: rdata[1:0] = r_q.mask;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    r_d.adv = 1'b0;
    r_d.chain = chain;
    ev_set = 2'b00;

    // Character sequencer: feed, sense, start, data pulses, stop
    // Each pulse lasts eff_div cycles, timed down to zero; the chain
    // is looked at only in idle and at the end of the stop pulse
    case (r_q.fsm)
      tsx_pkg::ST_IDLE:
      begin
        r_d.line = tsx_next_line(r_q.line, tsx_pkg::LINE_MARK); // RULE1 RULE16
        if (go)
        begin
          r_d.adv = 1'b1; // RULE6
          r_d.fsm = tsx_pkg::ST_FEED;
        end
      end
      tsx_pkg::ST_FEED:
      begin
        // Tape settles one cycle before the pins are read
        r_d.fsm = tsx_pkg::ST_SENSE;
      end
      tsx_pkg::ST_SENSE:
      begin
        r_d.hold = sense.code; // RULE7 RULE8
        // An empty reader must read as every position punched
        if (!sense.tape_present)
        begin
          r_d.hold = '1; // RULE15
        end
        if (!r_q.ctrl[tsx_pkg::CTRL_SIX_BIT])
        begin
          r_d.hold[5] = 1'b0; // RULE2
        end
        r_d.cnt = tsx_dec(eff_div);
        r_d.line = tsx_next_line(r_q.line, tsx_pkg::LINE_SPACE); // RULE9 RULE3
        r_d.fsm = tsx_pkg::ST_START;
      end
      tsx_pkg::ST_START:
      begin
        if (tick)
        begin
          r_d.cnt = tsx_dec(eff_div);
          r_d.pos = 3'h0;
          r_d.line = tsx_next_line(r_q.line, r_q.hold[0]); // RULE11 RULE16
          r_d.fsm = tsx_pkg::ST_DATA;
        end
        else
        begin
          r_d.cnt = tsx_dec(r_q.cnt);
        end
      end
      tsx_pkg::ST_DATA:
      begin
        if (tick)
        begin
          r_d.cnt = tsx_dec(eff_div);
          if (last)
          begin
            r_d.line = tsx_next_line(r_q.line, tsx_pkg::LINE_MARK); // RULE13
            r_d.fsm = tsx_pkg::ST_STOP;
          end
          else
          begin
            r_d.pos = r_q.pos + 3'h1;
            r_d.line = tsx_next_line(r_q.line,
              r_q.hold[r_q.pos + 3'h1]); // RULE11 RULE3
          end
        end
        else
        begin
          r_d.cnt = tsx_dec(r_q.cnt);
        end
      end
      tsx_pkg::ST_STOP:
      begin
        // Chain is only checked here, so a character is never cut short
        if (tick)
        begin
          ev_set[tsx_pkg::EV_CHAR_BIT] = 1'b1;
          if (go)
          begin
            r_d.adv = 1'b1; // RULE14 RULE6
            r_d.fsm = tsx_pkg::ST_FEED;
          end
          else
          begin
            r_d.fsm = tsx_pkg::ST_IDLE; // RULE17 RULE1
          end
        end
        else
        begin
          r_d.cnt = tsx_dec(r_q.cnt);
        end
      end
      default:
      begin
        r_d.fsm = tsx_pkg::ST_IDLE;
        r_d.line = tsx_pkg::LINE_MARK;
      end
    endcase

    // Interlock opening is reported as an event
    if (r_q.chain && !chain)
    begin
      ev_set[tsx_pkg::EV_HALT_BIT] = 1'b1; // RULE1
    end

    // Register writes
    if (wr)
    begin
      case (paddr)
        tsx_pkg::ADDR_CTRL: r_d.ctrl = pwdata[1:0];
        tsx_pkg::ADDR_DIV: r_d.div = pwdata[tsx_pkg::DIV_W-1:0]; // RULE4
        tsx_pkg::ADDR_IRQ_STAT: r_d.ev = r_q.ev & ~pwdata[1:0];
        tsx_pkg::ADDR_IRQ_MASK: r_d.mask = pwdata[1:0];
        default: r_d.ev = r_d.ev;
      endcase
    end
    // Set after clear so a simultaneous event is never lost
    r_d.ev = r_d.ev | ev_set;
    r_d.irq = |(r_d.ev & r_d.mask);

    // Bus answer
    r_d.rsp.pready = rd;
    r_d.rsp.pslverr = rd & ~hit;
    if (rd)
    begin
      r_d.rsp.prdata = (rd && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q.fsm <= tsx_pkg::ST_IDLE;
      r_q.cnt <= '0;
      r_q.pos <= 3'h0;
      r_q.hold <= '0;
      r_q.line <= tsx_pkg::LINE_MARK;
      r_q.adv <= 1'b0;
      r_q.chain <= 1'b0;
      r_q.ctrl <= tsx_pkg::CTRL_RST;
      r_q.div <= tsx_pkg::DIV_RST;
      r_q.ev <= 2'h0;
      r_q.mask <= tsx_pkg::MASK_RST;
      r_q.irq <= 1'b0;
      r_q.rsp <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign pready = r_q.rsp.pready;
  assign pslverr = r_q.rsp.pslverr;
  assign prdata = r_q.rsp.prdata;
  assign tape_advance = r_q.adv;
  assign line_mark = r_q.line;
  assign irq = r_q.irq;

endmodule

/* File: test/tsx_chk.sv */
/*
  Port checker for the tape transmitter top.
  Assumes the design runs with the same MIN_PULSE_CYC as handed here.
*/
`timescale 1ns/1ps
module tsx_chk #(
  parameter int MIN_PULSE_CYC = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and line
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire tsx_pkg::tsx_sense_t sense,
  input wire logic tape_advance,
  input wire logic line_mark
);
  logic lm_q;
  logic [23:0] run_q;
  logic go_w;
  // Sensor part of the start condition
  assign go_w = sense.run_sw & sense.tape_present & ~sense.tight_tape &
    sense.drive_running & sense.ext_ok;
  // Cycles the line held its level; reset value avoids a false first fire
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lm_q <= 1'b1;
      run_q <= 24'(MIN_PULSE_CYC);
    end
    else
    begin
      lm_q <= line_mark;
      run_q <= (line_mark != lm_q) ? 24'h00_0001 : run_q + 24'h00_0001;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PULSE_LEN:
  assert property ((line_mark != lm_q) |-> run_q >= 24'(MIN_PULSE_CYC))
    else $error("line pulse shorter than one interval");
  AST_ADV_GO:
  assert property (tape_advance |-> $past(go_w))
    else $error("tape advanced with run chain open");
  AST_START_SPACE:
  assert property (tape_advance |=> line_mark ##1 !line_mark)
    else $error("start pulse not spacing after sensing");
  AST_ADV_ONE:
  assert property (tape_advance |=> !tape_advance [*8])
    else $error("tape advanced more than once per character");
  AST_ADV_MARK:
  assert property (tape_advance |-> line_mark)
    else $error("line not marking between characters");
  AST_PRDY_ONE:
  assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PRDY_WAIT:
  assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  AST_ERR_RDY:
  assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule
bind tsx_top tsx_chk #(.MIN_PULSE_CYC(MIN_PULSE_CYC)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .sense(sense), .tape_advance(tape_advance),
  .line_mark(line_mark));

/* File: test/tsx_rx_model.sv */
/*
  Receiving station model: decodes start-stop characters off the line.
  Assumes a fixed pulse interval of PER clock cycles.
*/
`timescale 1ns/1ps
module tsx_rx_model #(
  parameter int PER = 8
) (
  // Line side
  input wire logic pclk,
  input wire logic line_mark,
  input wire logic six,
  // Decoded result
  output logic [5:0] rx_code,
  output int rx_count,
  output logic rx_bad
);
  // Mid-pulse sampling keeps clear of the line's own edges
  initial
  begin
    rx_code = 6'h00;
    rx_count = 0;
    rx_bad = 1'b0;
    forever
    begin
      @(negedge line_mark);
      rx_code = 6'h00;
      repeat (PER / 2) @(posedge pclk);
      if (line_mark) rx_bad = 1'b1;
      for (int i = 0; i < (six ? 6 : 5); i++)
      begin
        repeat (PER) @(posedge pclk);
        rx_code[i] = line_mark;
      end
      repeat (PER) @(posedge pclk);
      if (!line_mark) rx_bad = 1'b1;
      rx_count++;
    end
  end
endmodule

/* File: test/tsx_top_tb_top.sv */
/*
  Bench for the tape transmitter: APB master, tape reader stimulus and
  a line receiver model. Assumes one clock and a registered APB slave.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tsx_top_tb_top;
  localparam int PER = 8;
  // Programmed interval above the clamp, so the register really counts
  localparam int SLOW = 12;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic tape_advance, line_mark, irq, six, rx_bad;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] rx_code;
  tsx_pkg::tsx_sense_t sense;
  int rx_count, num_errors, checked, adv_n, cyc, at, gap;
  tsx_top #(.MIN_PULSE_CYC(PER)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .sense(sense), .tape_advance(tape_advance),
    .line_mark(line_mark), .irq(irq));
  tsx_rx_model #(.PER(PER)) rx (.pclk(pclk), .line_mark(line_mark),
    .six(six), .rx_code(rx_code), .rx_count(rx_count), .rx_bad(rx_bad));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Advance count and spacing between advances
  always @(posedge pclk)
  begin
    cyc++;
    if (tape_advance === 1'b1)
    begin
      gap = cyc - at;
      at = cyc;
      adv_n++;
    end
  end
  task automatic close_out();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; an idle edge follows so strobes never re-assert
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      num_errors++;
      close_out();
    end
    else
      @(posedge pclk);
  endtask
  task automatic wait_rx(input int tgt);
    int n;
    n = 0;
    while (rx_count < tgt && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 3000)
    begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic t_regs();
    apb(1'b0, tsx_pkg::ADDR_DIV, 32'h0000_0000);
    `CHK("div reset", 32'(tsx_pkg::DIV_RST), rd)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    $display("t_regs done");
  endtask
  // Five-level characters back to back; clamped short divider
  task automatic t_five();
    int c0, a0;
    c0 = rx_count;
    a0 = adv_n;
    apb(1'b1, tsx_pkg::ADDR_DIV, 32'h0000_0002);
    apb(1'b1, tsx_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, tsx_pkg::ADDR_CTRL, 32'h0000_0001);
    wait_rx(c0 + 2);
    `CHK("code5", 6'h0D, rx_code)
    `CHK("frame5", 1'b0, rx_bad)
    `CHK("adv per char", 1'b1, adv_n - a0 == 2)
    `CHK("char gap", 1'b1, gap == 2 + 7 * PER)
    `CHK("irq char", 1'b1, irq)
    apb(1'b1, tsx_pkg::ADDR_CTRL, 32'h0000_0000);
    idle(10 * PER);
    a0 = adv_n;
    idle(10 * PER);
    `CHK("stopped", 1'b1, adv_n == a0)
    `CHK("idle mark", 1'b1, line_mark)
    apb(1'b1, tsx_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    idle(2);
    `CHK("irq clear", 1'b0, irq)
    $display("t_five done");
  endtask
  // Six-level character with the run switch opened while in data
  task automatic t_six_halt();
    int c0, a0;
    sense.run_sw <= 1'b0;
    sense.code <= 6'h26;
    six = 1'b1;
    apb(1'b1, tsx_pkg::ADDR_CTRL, 32'h0000_0003);
    c0 = rx_count;
    sense.run_sw <= 1'b1;
    idle(3 + 2 * PER);
    sense.run_sw <= 1'b0;
    wait_rx(c0 + 1);
    `CHK("code6", 6'h26, rx_code)
    `CHK("frame6", 1'b0, rx_bad)
    a0 = adv_n;
    idle(10 * PER);
    `CHK("halted", 1'b1, adv_n == a0)
    `CHK("halt mark", 1'b1, line_mark)
    apb(1'b0, tsx_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK("halt event", 2'h3, rd[1:0])
    apb(1'b1, tsx_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    idle(2);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, tsx_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    apb(1'b0, tsx_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK("stat clear", 32'h0000_0000, rd)
    $display("t_six_halt done");
  endtask
  // Tape out, then tight tape: no character may start
  task automatic t_locks();
    int a0;
    for (int k = 0; k < 2; k++)
    begin
      a0 = adv_n;
      sense.run_sw <= 1'b1;
      sense.tape_present <= (k == 1);
      sense.tight_tape <= (k == 1);
      sense.code <= 6'h3F;
      idle(10 * PER);
      `CHK("locked", 1'b1, adv_n == a0)
      `CHK("lock mark", 1'b1, line_mark)
    end
    $display("t_locks done");
  endtask
  // Six-level run at a slower programmed rate: interval follows DIV
  task automatic t_rate();
    int a0, n;
    apb(1'b1, tsx_pkg::ADDR_DIV, 32'(SLOW));
    apb(1'b0, tsx_pkg::ADDR_DIV, 32'h0000_0000);
    `CHK("div write", 32'(SLOW), rd)
    a0 = adv_n;
    n = 0;
    sense.tight_tape <= 1'b0;
    sense.code <= 6'h2D;
    while (adv_n - a0 < 2 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      close_out();
    end
    `CHK("slow gap", 1'b1, gap == 2 + 8 * SLOW)
    sense.run_sw <= 1'b0;
    $display("t_rate done");
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, six} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sense = '{code: 6'h2D, tape_present: 1'b1, tight_tape: 1'b0,
      run_sw: 1'b1, drive_running: 1'b1, ext_ok: 1'b1};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_five();
    t_six_halt();
    t_locks();
    t_rate();
    close_out();
  end
endmodule
